// ---- core/fcb_pkg.sv ----
package fcb_pkg;
  localparam int ADDR_W   = 19;
  localparam int DATA_W   = 16;
  localparam int NUM_SECT = 9;
  localparam int SECT_W   = 4;
  localparam int BIDX_W   = 5;
  localparam int AS_W     = 2;
  localparam int PCNT_W   = 8;
  localparam int TMR_W    = 8;
  localparam int DIV_W    = 4;

  // Linear 32 burst: last index of the wrap window
  localparam logic [BIDX_W-1:0] BURST_LAST = 5'h1f;
  localparam logic [BIDX_W-1:0] BURST_ONE  = 5'h01;

  // Command decoder codes shared by both ends
  localparam logic [ADDR_W-1:0] UNL1_ADDR      = 19'h00111;
  localparam logic [ADDR_W-1:0] UNL2_ADDR      = 19'h00222;
  localparam logic [DATA_W-1:0] UNL1_DATA      = 16'h0011;
  localparam logic [DATA_W-1:0] UNL2_DATA      = 16'h0022;
  localparam logic [DATA_W-1:0] CMD_RESET      = 16'h00ff;
  localparam logic [DATA_W-1:0] CMD_AUTOSEL    = 16'h0033;
  localparam logic [DATA_W-1:0] CMD_PROG       = 16'h0044;
  localparam logic [DATA_W-1:0] CMD_BURST_EN   = 16'h0066;
  localparam logic [DATA_W-1:0] CMD_BURST_DIS  = 16'h0068;
  localparam logic [DATA_W-1:0] CMD_BURST_CONF = 16'h0067;
  localparam logic [DATA_W-1:0] CMD_BYPASS     = 16'h0020;
  localparam logic [DATA_W-1:0] CMD_BYP_PROG   = 16'h00a0;
  localparam logic [DATA_W-1:0] CMD_BYP_EXIT1  = 16'h0090;
  localparam logic [DATA_W-1:0] CMD_BYP_EXIT2  = 16'h0000;

  // Identification words, values arbitrary
  localparam logic [DATA_W-1:0] MANUF_ID  = 16'h00a5;
  localparam logic [DATA_W-1:0] DEVICE_ID = 16'h005a;
  localparam logic [DATA_W-1:0] FLAG_SET  = 16'h0001;
  localparam logic [DATA_W-1:0] FLAG_CLR  = 16'h0000;
  localparam logic [AS_W-1:0]   AS_MANUF  = 2'h0;
  localparam logic [AS_W-1:0]   AS_DEVICE = 2'h1;
  localparam logic [AS_W-1:0]   AS_PROT   = 2'h2;
  localparam int ST_POLL_BIT  = 7;
  localparam int ST_FAULT_BIT = 5;

  localparam logic [ADDR_W-1:0] SECT_BASE [NUM_SECT] = '{19'h00000, 19'h02000, 19'h03000,
    19'h04000, 19'h10000, 19'h20000, 19'h30000, 19'h40000, 19'h60000};

  // Timing: link clock made by the host divider, program time in link clocks
  localparam int LINK_PERIOD_NS = 64;
  localparam int CORE_PERIOD_NS = 10;
  localparam int PROG_TIME_NS   = 1000;
  localparam int STROBE_NS      = 300;
  localparam int READ_NS        = 900;
  localparam logic [PCNT_W-1:0] PROG_CYC =
    PCNT_W'((PROG_TIME_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS);
  localparam logic [TMR_W-1:0] STROBE_CYC =
    TMR_W'((STROBE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
  localparam logic [TMR_W-1:0] READ_CYC =
    TMR_W'((READ_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);
  localparam logic [DIV_W-1:0] LINK_HALF_CYC   = 4'h3;
  localparam logic [TMR_W-1:0] BURST_WAIT_CLKS = 8'h03;

  typedef enum logic [3:0] {
    ST_READ = 4'h0, ST_UNL1 = 4'h1, ST_UNL2 = 4'h2, ST_PSETUP = 4'h3,
    ST_PROG = 4'h4, ST_FAULT = 4'h5, ST_AUTOSEL = 4'h6, ST_BEN = 4'h7,
    ST_BDIS = 4'h8, ST_BYP = 4'h9, ST_BYP_PSET = 4'ha, ST_BYP_EXIT = 4'hb
  } fcb_dev_state_type;

  typedef enum logic [3:0] {
    H_IDLE = 4'h0, H_WSET = 4'h1, H_WSTB = 4'h2, H_WHOLD = 4'h3, H_READ = 4'h4,
    H_BSET = 4'h5, H_BLOAD = 4'h6, H_BWAIT = 4'h7, H_BRUN = 4'h8
  } fcb_host_state_type;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0, OP_READ = 2'h1, OP_BURST = 2'h2
  } fcb_op_type;

  function automatic logic [SECT_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
    sector_of = '0;
    for (int i = 1; i < NUM_SECT; i++) begin
      if (a >= SECT_BASE[i]) sector_of = SECT_W'(i);
    end
  endfunction : sector_of

  function automatic logic is_cyc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                                  input logic [ADDR_W-1:0] ea, input logic [DATA_W-1:0] ed);
    is_cyc = (a == ea) && (d == ed);
  endfunction : is_cyc
endpackage : fcb_pkg

// ---- core/fcb_link_if.sv ----
`timescale 1ns/10ps
interface fcb_link_if;
  logic                        link_clk;
  logic                        ce_n;
  logic                        we_n;
  logic                        oe_n;
  logic                        load_burst_address_n;
  logic                        burst_advance_n;
  logic                        burst_end_n;
  logic [fcb_pkg::ADDR_W-1:0]  addr;
  logic [fcb_pkg::DATA_W-1:0]  dq_h;
  logic                        dq_h_oe;
  logic [fcb_pkg::DATA_W-1:0]  dq_d;
  logic                        dq_d_oe;
  logic [fcb_pkg::DATA_W-1:0]  dq;

  // Shared data wire; the device only drives while the host reads
  assign dq = dq_d_oe ? dq_d : dq_h;

  modport host (output link_clk, ce_n, we_n, oe_n, load_burst_address_n, burst_advance_n,
                addr, dq_h, dq_h_oe, input dq, burst_end_n);
  modport device (input link_clk, ce_n, we_n, oe_n, load_burst_address_n, burst_advance_n,
                  addr, dq, output dq_d, dq_d_oe, burst_end_n);
endinterface : fcb_link_if

// ---- core/fcb_sync2.sv ----
`timescale 1ns/10ps
module fcb_sync2 #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         clk_en_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_ff <= RST_VAL;
      q_o     <= RST_VAL;
    end else if (clk_en_i) begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end
endmodule : fcb_sync2

// ---- core/fcb_device.sv ----
`timescale 1ns/10ps
// Operation
// R1 - Write needs chip and strobe low, output high
// R2 - Strobe held low at reset is ignored
// R3 - Only correct sequences act, else read
// R4 - Address taken when write cycle opens
// R5 - Data taken when write cycle closes
// R6 - Read mode at reset and after program
// R7 - Suspended sectors read status, others array
// R8 - Host resets after fault or autoselect
// R9 - Starts asynchronous; burst after enable sequence
// R10 - Burst address loaded on load strobe
// R11 - Host releases load strobe before next edge
// R12 - Advance strobe steps burst each edge
// R13 - End flag low on thirty-second word
// R14 - Burst ends by disable or hardware reset
// R15 - Reset command returns read, ignored while busy
// R16 - Autoselect entered by unlocks plus command
// R17 - Offsets zero, one give identity words
// R18 - Offsets two, three give protect, burst
// R19 - Four-cycle program; busy ignores commands
// R20 - Programming never turns zero into one
// R21 - Bypass entry, then two-cycle programming
// R22 - Bypass accepts only program and exit
// R23 - Command codes shared as package constants
module fcb_device (
  input  wire logic                            link_clk_i,
  input  wire logic                            sys_rst_i,
  input  wire logic                            clk_en_i,
  fcb_link_if.device                           link,
  input  wire logic [fcb_pkg::NUM_SECT-1:0]    prot_mask_i,
  input  wire logic [fcb_pkg::NUM_SECT-1:0]    susp_mask_i,
  output logic                                 busy_o,
  output logic                                 burst_mode_o,
  output logic                                 fault_o
);
  import fcb_pkg::*;

  logic [2:0]        strb_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic              wr_act;
  logic              rd_act;
  logic              wr_act_ff;
  logic              armed_ff;
  logic              in_cyc_ff;
  logic              wr_start;
  logic              wr_end;
  logic [ADDR_W-1:0] wr_addr_ff;
  fcb_dev_state_type state_ff;
  fcb_dev_state_type nxt_state;
  logic              burst_mode_ff;
  logic              nxt_burst_mode;
  logic              start_prog;
  logic              prog_bad;
  logic              prog_done;
  logic [PCNT_W-1:0] prog_cnt_ff;
  logic [ADDR_W-1:0] prog_addr_ff;
  logic [DATA_W-1:0] prog_data_ff;
  logic              byp_ret_ff;
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic              burst_on_ff;
  logic [ADDR_W-1:0] baddr_ff;
  logic [ADDR_W-1:0] nxt_baddr;
  logic [BIDX_W-1:0] bcnt_ff;
  logic [BIDX_W-1:0] nxt_bcnt;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] status;
  logic [DATA_W-1:0] rd_word;

  // R2 strobes reset to a write level, so a held write never arms
  fcb_sync2 #(.W(3), .RST_VAL(3'h1)) u_sync_strb (
    .clk_i     (link_clk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .d_i       ({link.ce_n, link.we_n, link.oe_n}),
    .q_o       (strb_s)
  );
  fcb_sync2 #(.W(ADDR_W + DATA_W), .RST_VAL('0)) u_sync_bus (
    .clk_i     (link_clk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .d_i       ({link.addr, link.dq}),
    .q_o       ({addr_s, data_s})
  );

  // R1 qualified write and read levels
  assign wr_act = ~strb_s[2] & ~strb_s[1] & strb_s[0];
  assign rd_act = ~strb_s[2] & ~strb_s[0];
  // R2 a write must open after reset to count
  assign wr_start = wr_act & ~wr_act_ff & armed_ff;
  assign wr_end   = ~wr_act & wr_act_ff & in_cyc_ff;

  // Write cycle tracking and address latch
  always_ff @(posedge link_clk_i) begin
    if (sys_rst_i) begin
      wr_act_ff  <= 1'b0;
      armed_ff   <= 1'b0;
      in_cyc_ff  <= 1'b0;
      wr_addr_ff <= '0;
    end else if (clk_en_i) begin
      wr_act_ff <= wr_act;
      // R2 arm only once the strobes were seen at any level other than a write
      if (!wr_act) armed_ff <= 1'b1;
      if (wr_start) in_cyc_ff <= 1'b1;
      else if (wr_end) in_cyc_ff <= 1'b0;
      // R4 later falling edge opens the cycle
      if (wr_start) wr_addr_ff <= addr_s;
    end
  end

  // R20 a one over a stored zero faults
  assign prog_bad  = |(data_s & ~mem[wr_addr_ff]);
  assign prog_done = (state_ff == ST_PROG) && (prog_cnt_ff == '0);

  // Command interpreter; data is taken as the write closes (R5)
  always_comb begin
    nxt_state      = state_ff;
    nxt_burst_mode = burst_mode_ff;
    start_prog     = 1'b0;
    if (state_ff == ST_PROG) begin
      // R6 routine done returns to reading, or to bypass after a bypass program
      if (prog_done) nxt_state = byp_ret_ff ? ST_BYP : ST_READ;
    end else if (wr_end) begin
      case (state_ff)
        // R19 address and data start the routine
        ST_PSETUP, ST_BYP_PSET: begin
          start_prog = 1'b1;
        end
        // R22 bypass ignores everything but its own commands
        ST_BYP: begin
          if (data_s == CMD_BYP_PROG) nxt_state = ST_BYP_PSET;
          else if (data_s == CMD_BYP_EXIT1) nxt_state = ST_BYP_EXIT;
        end
        ST_BYP_EXIT: begin
          nxt_state = (data_s == CMD_BYP_EXIT2) ? ST_READ : ST_BYP;
        end
        default: begin
          // R15 reset ignores the address
          if (data_s == CMD_RESET) nxt_state = ST_READ;
          // R3 every wrong step drops back to read
          else if (state_ff == ST_READ) begin
            nxt_state = is_cyc(wr_addr_ff, data_s, UNL1_ADDR, UNL1_DATA) ? ST_UNL1 : ST_READ;
          end else if (state_ff == ST_UNL1) begin
            nxt_state = is_cyc(wr_addr_ff, data_s, UNL2_ADDR, UNL2_DATA) ? ST_UNL2 : ST_READ;
          end else if (state_ff == ST_UNL2) begin
            nxt_state = ST_READ;
            // R16 autoselect entry
            if (is_cyc(wr_addr_ff, data_s, UNL1_ADDR, CMD_AUTOSEL)) nxt_state = ST_AUTOSEL;
            if (is_cyc(wr_addr_ff, data_s, UNL1_ADDR, CMD_PROG)) nxt_state = ST_PSETUP;
            // R21 bypass entry
            if (is_cyc(wr_addr_ff, data_s, UNL1_ADDR, CMD_BYPASS)) nxt_state = ST_BYP;
            if (is_cyc(wr_addr_ff, data_s, UNL1_ADDR, CMD_BURST_EN)) nxt_state = ST_BEN;
            if (is_cyc(wr_addr_ff, data_s, UNL1_ADDR, CMD_BURST_DIS)) nxt_state = ST_BDIS;
          end else if (state_ff == ST_BEN || state_ff == ST_BDIS) begin
            nxt_state = ST_READ;
            // R9 fourth cycle switches burst mode; R14 disable
            if (is_cyc(wr_addr_ff, data_s, UNL1_ADDR, CMD_BURST_CONF)) begin
              nxt_burst_mode = (state_ff == ST_BEN);
            end
          end
          // Autoselect and fault hold until a reset command
        end
      endcase
      if (start_prog) nxt_state = prog_bad ? ST_FAULT : ST_PROG;
    end
  end

  // State and burst mode; R14 hardware reset clears burst mode
  always_ff @(posedge link_clk_i) begin
    if (sys_rst_i) begin
      state_ff      <= ST_READ;
      burst_mode_ff <= 1'b0;
    end else if (clk_en_i) begin
      state_ff      <= nxt_state;
      burst_mode_ff <= nxt_burst_mode;
    end
  end

  // Program routine timer; reset above aborts it
  always_ff @(posedge link_clk_i) begin
    if (sys_rst_i) begin
      prog_cnt_ff  <= '0;
      prog_addr_ff <= '0;
      prog_data_ff <= '0;
      byp_ret_ff   <= 1'b0;
    end else if (clk_en_i) begin
      if (start_prog) begin
        prog_cnt_ff  <= PROG_CYC;
        prog_addr_ff <= wr_addr_ff;
        prog_data_ff <= data_s;
        byp_ret_ff   <= (state_ff == ST_BYP_PSET);
      end else if (state_ff == ST_PROG && prog_cnt_ff != '0) begin
        prog_cnt_ff <= prog_cnt_ff - 1'b1;
      end
    end
  end

  // Array has no reset; contents are whatever was programmed
  always_ff @(posedge link_clk_i) begin
    // R20 only ever clears bits
    if (clk_en_i && !sys_rst_i && prog_done) begin
      mem[prog_addr_ff] <= mem[prog_addr_ff] & prog_data_ff;
    end
  end

  // R12 step within the 32-word window, address wraps
  always_comb begin
    nxt_baddr = baddr_ff;
    nxt_bcnt  = bcnt_ff;
    if (burst_on_ff && !link.burst_advance_n && bcnt_ff != BURST_LAST) begin
      nxt_baddr = {baddr_ff[ADDR_W-1:BIDX_W], baddr_ff[BIDX_W-1:0] + BURST_ONE};
      nxt_bcnt  = bcnt_ff + BURST_ONE;
    end
  end

  // Burst strobes already run on this clock, so no synchroniser
  always_ff @(posedge link_clk_i) begin
    if (sys_rst_i) begin
      burst_on_ff <= 1'b0;
      baddr_ff    <= '0;
      bcnt_ff     <= '0;
    end else if (clk_en_i) begin
      // R10 load start address on the strobe edge
      if (burst_mode_ff && !link.load_burst_address_n) begin
        burst_on_ff <= 1'b1;
        baddr_ff    <= addr_s;
        bcnt_ff     <= '0;
      end else begin
        burst_on_ff <= burst_on_ff & rd_act;
        baddr_ff    <= nxt_baddr;
        bcnt_ff     <= nxt_bcnt;
      end
    end
  end

  // Status word: inverted poll bit and fault flag
  always_comb begin
    status               = '0;
    status[ST_POLL_BIT]  = ~prog_data_ff[ST_POLL_BIT];
    status[ST_FAULT_BIT] = (state_ff == ST_FAULT);
  end

  assign rd_addr = burst_on_ff ? nxt_baddr : addr_s;

  // Read data selection
  always_comb begin
    case (state_ff)
      ST_AUTOSEL: begin
        // R17 identity words; R18 protect and burst flags
        if (rd_addr[AS_W-1:0] == AS_MANUF) rd_word = MANUF_ID;
        else if (rd_addr[AS_W-1:0] == AS_DEVICE) rd_word = DEVICE_ID;
        else if (rd_addr[AS_W-1:0] == AS_PROT) begin
          rd_word = prot_mask_i[sector_of(rd_addr)] ? FLAG_SET : FLAG_CLR;
        end else rd_word = burst_mode_ff ? FLAG_SET : FLAG_CLR;
      end
      ST_PROG, ST_FAULT: rd_word = status;
      default: begin
        // R7 suspended sectors show status, the rest the array
        rd_word = susp_mask_i[sector_of(rd_addr)] ? status : mem[rd_addr];
      end
    endcase
  end

  // Registered pin and user outputs
  always_ff @(posedge link_clk_i) begin
    if (sys_rst_i) begin
      link.dq_d        <= '0;
      link.dq_d_oe     <= 1'b0;
      link.burst_end_n <= 1'b1;
      busy_o           <= 1'b0;
      burst_mode_o     <= 1'b0;
      fault_o          <= 1'b0;
    end else if (clk_en_i) begin
      link.dq_d    <= rd_word;
      link.dq_d_oe <= rd_act;
      // R13 low while the last word of the burst is out
      link.burst_end_n <= ~(burst_on_ff && nxt_bcnt == BURST_LAST);
      busy_o           <= (nxt_state == ST_PROG);
      burst_mode_o     <= nxt_burst_mode;
      fault_o          <= (nxt_state == ST_FAULT);
    end
  end
endmodule : fcb_device

// ---- core/fcb_host.sv ----
`timescale 1ns/10ps
module fcb_host (
  input  wire logic                          core_clk_i,
  input  wire logic                          sys_rst_i,
  input  wire logic                          clk_en_i,
  fcb_link_if.host                           link,
  input  wire logic                          req_valid_i,
  input  wire fcb_pkg::fcb_op_type           req_op_i,
  input  wire logic [fcb_pkg::ADDR_W-1:0]    req_addr_i,
  input  wire logic [fcb_pkg::DATA_W-1:0]    req_data_i,
  output logic                               req_ready_o,
  output logic                               rd_valid_o,
  output logic [fcb_pkg::DATA_W-1:0]         rd_data_o,
  output logic                               rd_last_o
);
  import fcb_pkg::*;

  fcb_host_state_type state_ff;
  logic [TMR_W-1:0]   tmr_ff;
  logic [DIV_W-1:0]   div_ff;
  logic               lclk_ff;
  logic               rise_now;
  logic               fall_now;
  logic               end_s;
  logic [DATA_W-1:0]  dq_s;

  // Divider makes the link clock; burst load and first advance change at falls
  assign rise_now = (div_ff == LINK_HALF_CYC - 1'b1) && !lclk_ff;
  assign fall_now = (div_ff == LINK_HALF_CYC - 1'b1) && lclk_ff;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      div_ff  <= '0;
      lclk_ff <= 1'b0;
    end else if (clk_en_i) begin
      if (rise_now || fall_now) begin
        div_ff  <= '0;
        lclk_ff <= ~lclk_ff;
      end else begin
        div_ff <= div_ff + 1'b1;
      end
    end
  end
  assign link.link_clk = lclk_ff;

  // Device outputs come from the link domain
  fcb_sync2 #(.W(DATA_W + 1), .RST_VAL('1)) u_sync_rd (
    .clk_i     (core_clk_i),
    .sys_rst_i (sys_rst_i),
    .clk_en_i  (clk_en_i),
    .d_i       ({link.burst_end_n, link.dq}),
    .q_o       ({end_s, dq_s})
  );

  // Bus sequencer
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      state_ff                  <= H_IDLE;
      tmr_ff                    <= '0;
      link.ce_n                 <= 1'b1;
      link.we_n                 <= 1'b1;
      link.oe_n                 <= 1'b1;
      link.load_burst_address_n <= 1'b1;
      link.burst_advance_n      <= 1'b1;
      link.addr                 <= '0;
      link.dq_h                 <= '0;
      link.dq_h_oe              <= 1'b0;
      req_ready_o               <= 1'b0;
      rd_valid_o                <= 1'b0;
      rd_data_o                 <= '0;
      rd_last_o                 <= 1'b0;
    end else if (clk_en_i) begin
      rd_valid_o <= 1'b0;
      rd_last_o  <= 1'b0;
      // Burst wait counts link clocks on its own, not core cycles
      if (tmr_ff != '0 && state_ff != H_BWAIT) tmr_ff <= tmr_ff - 1'b1;
      case (state_ff)
        H_IDLE: begin
          req_ready_o <= 1'b1;
          if (req_valid_i && req_ready_o) begin
            req_ready_o <= 1'b0;
            link.addr   <= req_addr_i;
            link.dq_h   <= req_data_i;
            link.ce_n   <= 1'b0;
            tmr_ff      <= STROBE_CYC;
            // R1 writes keep output enable high
            if (req_op_i == OP_WRITE) begin
              link.dq_h_oe <= 1'b1;
              state_ff     <= H_WSET;
            end else begin
              link.oe_n <= 1'b0;
              if (req_op_i == OP_READ) tmr_ff <= READ_CYC;
              state_ff <= (req_op_i == OP_READ) ? H_READ : H_BSET;
            end
          end
        end
        H_WSET: begin
          if (tmr_ff == '0) begin
            link.we_n <= 1'b0;
            tmr_ff    <= STROBE_CYC;
            state_ff  <= H_WSTB;
          end
        end
        H_WSTB: begin
          if (tmr_ff == '0) begin
            link.we_n <= 1'b1;
            tmr_ff    <= STROBE_CYC;
            state_ff  <= H_WHOLD;
          end
        end
        H_WHOLD: begin
          if (tmr_ff == '0) begin
            link.ce_n    <= 1'b1;
            link.dq_h_oe <= 1'b0;
            tmr_ff       <= STROBE_CYC;
            state_ff     <= H_READ;
          end
        end
        H_READ: begin
          if (tmr_ff == '0) begin
            if (!link.oe_n) begin
              rd_valid_o <= 1'b1;
              rd_last_o  <= 1'b1;
              rd_data_o  <= dq_s;
            end
            // Turnaround: the device needs link clocks to release the data wire
            link.ce_n <= 1'b1;
            link.oe_n <= 1'b1;
            tmr_ff    <= STROBE_CYC;
            state_ff  <= link.oe_n ? H_IDLE : H_WHOLD;
          end
        end
        H_BSET: begin
          // R10 load strobe set at a fall, held across a rise
          if (tmr_ff == '0 && fall_now) begin
            link.load_burst_address_n <= 1'b0;
            state_ff                  <= H_BLOAD;
          end
        end
        H_BLOAD: begin
          // R11 high again before the following rise
          if (fall_now) begin
            link.load_burst_address_n <= 1'b1;
            tmr_ff                    <= BURST_WAIT_CLKS;
            state_ff                  <= H_BWAIT;
          end
        end
        H_BWAIT: begin
          if (fall_now) begin
            if (tmr_ff == '0) begin
              link.burst_advance_n <= 1'b0;
              state_ff             <= H_BRUN;
            end else begin
              tmr_ff <= tmr_ff - 1'b1;
            end
          end
        end
        H_BRUN: begin
          // R12 sample each word just before the advancing rise
          if (rise_now) begin
            rd_valid_o <= 1'b1;
            rd_data_o  <= dq_s;
            // R13 end flag closes the burst
            if (!end_s) begin
              rd_last_o            <= 1'b1;
              link.burst_advance_n <= 1'b1;
              link.ce_n            <= 1'b1;
              link.oe_n            <= 1'b1;
              tmr_ff               <= STROBE_CYC;
              state_ff             <= H_WHOLD;
            end
          end
        end
        default: state_ff <= H_IDLE;
      endcase
    end
  end
endmodule : fcb_host

// ---- test/fcb_link_monitor.sv ----
`timescale 1ns/10ps
module fcb_link_monitor (
  input wire logic link_clk,
  input wire logic sys_rst_i,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic load_burst_address_n,
  input wire logic burst_advance_n,
  input wire logic dq_h_oe,
  input wire logic dq_d_oe
);
  // All checks run on the link clock, quiet while the device is in reset
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (sys_rst_i);
  // Burst opening: the load strobe, then the wait for the first word
  sequence load_s; !load_burst_address_n; endsequence
  sequence wait_s; burst_advance_n [*3]; endsequence
  a_write_no_oe: assert property (!we_n |-> oe_n) else $error("write with output on");
  a_write_needs_ce: assert property (!we_n |-> !ce_n) else $error("write w/o select");
  a_write_has_data: assert property (!we_n |-> dq_h_oe && !dq_d_oe)
    else $error("write data not driven");
  a_load_one_clk: assert property (load_s |=> load_burst_address_n)
    else $error("load strobe too long");
  a_load_in_read: assert property (load_s |-> !ce_n && !oe_n) else $error("load outside read");
  a_wait_first: assert property (load_s |=> wait_s) else $error("advance too early");
  // Output disable must release the shared data wire
  a_idle_quiet: assert property (oe_n [*5] |-> !dq_d_oe) else $error("device drives idle");
  a_no_clash: assert property (!(dq_d_oe && dq_h_oe)) else $error("both ends drive");
endmodule : fcb_link_monitor

// ---- test/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  import fcb_pkg::*;
  logic                core_clk_i = 1'b0;
  logic                rst_h      = 1'b1;
  logic                rst_d      = 1'b1;
  logic                vld        = 1'b0;
  fcb_op_type          op         = OP_READ;
  logic [ADDR_W-1:0]   adr        = '0;
  logic [DATA_W-1:0]   dat        = '0;
  logic [NUM_SECT-1:0] prot       = '0;
  logic [NUM_SECT-1:0] susp       = '0;
  logic                rdy, rv, rl, busy, bm;
  logic [DATA_W-1:0]   rdat;
  logic [15:0]         lf         = 16'h0011;
  int                  error_cnt  = 0;
  int                  comparisons = 0;
  int                  cyc        = 0;
  fcb_link_if lnk ();
  fcb_host i_fcb_host (.core_clk_i(core_clk_i), .sys_rst_i(rst_h), .clk_en_i(1'b1), .link(lnk),
    .req_valid_i(vld), .req_op_i(op), .req_addr_i(adr), .req_data_i(dat), .req_ready_o(rdy),
    .rd_valid_o(rv), .rd_data_o(rdat), .rd_last_o(rl));
  fcb_device i_fcb_device (.link_clk_i(lnk.link_clk), .sys_rst_i(rst_d), .clk_en_i(1'b1),
    .link(lnk), .prot_mask_i(prot), .susp_mask_i(susp), .busy_o(busy), .burst_mode_o(bm),
    .fault_o());
  fcb_link_monitor i_fcb_link_monitor (.link_clk(lnk.link_clk), .sys_rst_i(rst_d),
    .ce_n(lnk.ce_n), .we_n(lnk.we_n), .oe_n(lnk.oe_n), .dq_h_oe(lnk.dq_h_oe),
    .load_burst_address_n(lnk.load_burst_address_n), .burst_advance_n(lnk.burst_advance_n),
    .dq_d_oe(lnk.dq_d_oe));
  // Core clock
  always #5 core_clk_i = ~core_clk_i;
  // Host leaves reset first: its divider must clock the device out of reset
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8) rst_h <= 1'b0;
    if (cyc == 40) rst_d <= 1'b0;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Ready is looked at on the falling edge so the request never races it
  task automatic req(input fcb_op_type o, input logic [18:0] a, input logic [15:0] d);
    while (rdy !== 1'b1) @(negedge core_clk_i);
    @(posedge core_clk_i);
    vld <= 1'b1;
    op  <= o;
    adr <= a;
    dat <= d;
    @(posedge core_clk_i);
    vld <= 1'b0;
    @(negedge core_clk_i);
  endtask : req
  task automatic wr(input logic [18:0] a, input logic [15:0] d);
    req(OP_WRITE, a, d);
    // Return only once the write has left the link
    while (rdy !== 1'b1) @(negedge core_clk_i);
  endtask : wr
  task automatic rd(input logic [18:0] a, output logic [15:0] q);
    req(OP_READ, a, 16'h0000);
    while (rv !== 1'b1) @(negedge core_clk_i);
    q = rdat;
  endtask : rd
  task automatic unl(input logic [15:0] d2, input logic [15:0] c);
    wr(UNL1_ADDR, UNL1_DATA);
    wr(UNL2_ADDR, d2);
    wr(UNL1_ADDR, c);
  endtask : unl
  // Programs a zero word, which reads back zero whatever was stored
  task automatic prog_zero(input logic [15:0] c, input logic [18:0] a);
    logic [15:0] q;
    wr(a, 16'h0000);
    chk("busy", {15'h0000, busy}, 16'h0001);
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(negedge core_clk_i);
    if (c == CMD_BYP_PROG) begin
      wr(lf[14:0], CMD_BYP_EXIT1);
      wr(lf[15:1], CMD_BYP_EXIT2);
    end
    rd(a, q);
    chk("prog", q, 16'h0000);
  endtask : prog_zero
  task automatic end_of_test();
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // Main sequence
  initial begin
    logic [15:0] q;
    int          s;
    wait (rst_d === 1'b0);
    lf = lfsr(lf);
    prot <= lf[8:0];
    unl(UNL2_DATA, CMD_AUTOSEL);
    rd(19'h00000, q);
    chk("manuf", q, MANUF_ID);
    rd(19'h00001, q);
    chk("device", q, DEVICE_ID);
    for (int i = 0; i < 4; i++) begin
      lf = lfsr(lf);
      s = lf % NUM_SECT;
      rd(SECT_BASE[s] + 19'h00002, q);
      chk("prot", q, prot[s] ? FLAG_SET : FLAG_CLR);
    end
    rd(19'h00003, q);
    chk("async", q, FLAG_CLR);
    wr(lf[14:0], CMD_RESET);
    // Corrupt second unlock, then the real enable sequence
    unl(16'h0023, CMD_BURST_EN);
    wr(UNL1_ADDR, CMD_BURST_CONF);
    chk("no_burst", {15'h0000, bm}, 16'h0000);
    unl(UNL2_DATA, CMD_BURST_EN);
    wr(UNL1_ADDR, CMD_BURST_CONF);
    unl(UNL2_DATA, CMD_AUTOSEL);
    rd(19'h00003, q);
    chk("burst_flag", q, FLAG_SET);
    wr(lf[14:0], CMD_RESET);
    chk("keep_burst", {15'h0000, bm}, 16'h0001);
    req(OP_BURST, {3'h0, lf}, 16'h0000);
    for (s = 1; s < 40; s++) begin
      while (rv !== 1'b1) @(negedge core_clk_i);
      if (rl === 1'b1) break;
      @(negedge core_clk_i);
    end
    chk("words", 16'(s), 16'h0020);
    unl(UNL2_DATA, CMD_BURST_DIS);
    wr(UNL1_ADDR, CMD_BURST_CONF);
    chk("burst_off", {15'h0000, bm}, 16'h0000);
    prot <= 9'h000;
    unl(UNL2_DATA, CMD_BYPASS);
    wr(lf[14:0], CMD_BYP_PROG);
    prog_zero(CMD_BYP_PROG, {3'h0, lf});
    unl(UNL2_DATA, CMD_PROG);
    prog_zero(CMD_PROG, {3'h4, lf});
    susp <= 9'h001;
    rd(19'h00005, q);
    chk("susp", q, 16'h0080);
    end_of_test();
  end
endmodule : testbench
